// ---- common/sms_pkg.sv ----
`default_nettype none
package sms_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int CLK_PERIOD_NS = 5;
	// host serial clock half period
	localparam int SCLK_HALF_NS = 60;
	localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;
	// least time the host holds the reset pin low
	localparam int RST_HOLD_NS = 1000;
	localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// mode word: polarity high bit, phase low bit
	typedef logic [1:0] sms_mode_type;
	localparam int MODE_POL = 1;
	localparam int MODE_PHA = 0;
	localparam sms_mode_type MODE_RESET = 2'h0;
	// synchroniser lane positions in the device
	localparam int PIN_SCLK = 0;
	localparam int PIN_MOSI = 1;
	localparam int PIN_CS = 2;
	localparam int PIN_PHA = 3;
	localparam int PIN_POL = 4;
	localparam int PIN_RST = 5;
	localparam int PIN_W = 6;
endpackage
`default_nettype wire

// ---- common/sms_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface sms_link_if;
	logic sclk;
	logic slave_select_low;
	logic mosi;
	logic active_low_reset_pin;
	logic clock_polarity_select_o;
	logic clock_polarity_select_oe;
	logic clock_phase_select_o;
	logic clock_phase_select_oe;
	logic slave_serial_output_o;
	logic slave_serial_output_oe;
	logic clock_polarity_select;
	logic clock_phase_select;
	logic slave_serial_output;
	// weak pull-downs on the strap pins win when nobody drives them
	assign clock_polarity_select = clock_polarity_select_oe ? clock_polarity_select_o : 1'b0;
	assign clock_phase_select = clock_phase_select_oe ? clock_phase_select_o : 1'b0;
	// released output line reads low here
	assign slave_serial_output = slave_serial_output_oe ? slave_serial_output_o : 1'b0;
	modport device (
		input sclk, slave_select_low, mosi, active_low_reset_pin,
		input clock_polarity_select, clock_phase_select,
		output slave_serial_output_o, slave_serial_output_oe
	);
	modport host (
		output sclk, slave_select_low, mosi, active_low_reset_pin,
		output clock_polarity_select_o, clock_polarity_select_oe,
		output clock_phase_select_o, clock_phase_select_oe,
		input slave_serial_output
	);
endinterface
`default_nettype wire

// ---- rtl/sms_device.sv ----
// Overview of operation
// - mode straps latched on reset pin rise
// - strap pull-downs give mode zero default
// - polarity first strap, phase second strap
// - mode 0: sample rising, launch falling
// - mode 1: launch rising, sample falling
// - mode 2: sample falling, launch rising
// - mode 3: launch falling, sample rising
// - output released while select deasserted
`timescale 1ns/100ps
`default_nettype none
module sms_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	import sms_pkg::*;
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q, wr_d, rd_q, rd_d;
	logic push, pop;
	assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_q[rd_q[AW-1:0]];
	always_comb begin
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end
endmodule // sms_fifo

module sms_device #(
	parameter int DEPTH = sms_pkg::FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	sms_link_if.device link,
	output logic [sms_pkg::DATA_W-1:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic rx_space,
	input wire logic [sms_pkg::DATA_W-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output sms_pkg::sms_mode_type spi_mode,
	output logic frame_active
);
	import sms_pkg::*;
	logic [PIN_W-1:0] pins, meta_q, sync_q;
	logic sclk_prev_q, rst_prev_q;
	sms_mode_type mode_q, mode_d;
	logic [DATA_W-1:0] tx_q, tx_d, rx_q, rx_d, rx_byte;
	logic [$clog2(DATA_W)-1:0] cnt_q, cnt_d;
	logic act_q, act_d, out_q, out_d;
	logic sclk_rise, sclk_fall, lead, trail, sample, launch, rst_rise, cs_act, start;
	logic push, load;
	assign pins[PIN_SCLK] = link.sclk;
	assign pins[PIN_MOSI] = link.mosi;
	assign pins[PIN_CS] = link.slave_select_low;
	assign pins[PIN_PHA] = link.clock_phase_select;
	assign pins[PIN_POL] = link.clock_polarity_select;
	assign pins[PIN_RST] = link.active_low_reset_pin;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= '0;
			sync_q <= '0;
			sclk_prev_q <= 1'b0;
			rst_prev_q <= 1'b0;
		end else begin
			meta_q <= pins;
			sync_q <= meta_q;
			sclk_prev_q <= sync_q[PIN_SCLK];
			rst_prev_q <= sync_q[PIN_RST];
		end
	end
	assign sclk_rise = sync_q[PIN_SCLK] & ~sclk_prev_q;
	assign sclk_fall = ~sync_q[PIN_SCLK] & sclk_prev_q;
	assign rst_rise = sync_q[PIN_RST] & ~rst_prev_q;
	assign lead = mode_q[MODE_POL] ? sclk_fall : sclk_rise;
	assign trail = mode_q[MODE_POL] ? sclk_rise : sclk_fall;
	assign sample = mode_q[MODE_PHA] ? trail : lead;
	assign launch = mode_q[MODE_PHA] ? lead : trail;
	assign cs_act = ~sync_q[PIN_CS] & sync_q[PIN_RST];
	assign start = cs_act & ~act_q;
	assign rx_byte = {rx_q[DATA_W-2:0], sync_q[PIN_MOSI]};
	always_comb begin
		mode_d = mode_q;
		if (rst_rise) begin
			mode_d = {sync_q[PIN_POL], sync_q[PIN_PHA]};
		end
	end
	always_comb begin
		tx_d = tx_q;
		rx_d = rx_q;
		cnt_d = cnt_q;
		act_d = cs_act;
		push = 1'b0;
		load = 1'b0;
		if (!cs_act) begin
			cnt_d = '0;
		end else begin
			// phase 0 needs the first bit out before the first edge
			if (start && !mode_q[MODE_PHA]) begin
				load = 1'b1;
			end
			if (sample) begin
				rx_d = rx_byte;
				cnt_d = cnt_q + 1'b1;
				push = cnt_q == ($clog2(DATA_W))'(DATA_W-1);
			end
			if (launch && !start) begin
				if (cnt_q == '0) begin
					load = 1'b1;
				end else begin
					tx_d = {tx_q[DATA_W-2:0], 1'b0};
				end
			end
		end
		if (load) begin
			tx_d = tx_valid ? tx_data : '0;
		end
		out_d = tx_d[DATA_W-1];
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_q <= MODE_RESET;
			tx_q <= '0;
			rx_q <= '0;
			cnt_q <= '0;
			act_q <= 1'b0;
			out_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			cnt_q <= cnt_d;
			act_q <= act_d;
			out_q <= out_d;
		end
	end
	assign tx_ready = load;
	assign link.slave_serial_output_o = out_q;
	assign link.slave_serial_output_oe = act_q;
	assign spi_mode = mode_q;
	assign frame_active = act_q;
	sms_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(DEPTH)
	) u_rx_fifo (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.in_data(rx_byte),
		.in_valid(push),
		.in_ready(rx_space),
		.out_data(rx_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready)
	);
endmodule // sms_device
`default_nettype wire

// ---- rtl/sms_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module sms_host #(
	parameter int HALF_CYC = sms_pkg::SCLK_HALF_CYC,
	parameter int RST_CYC = sms_pkg::RST_HOLD_CYC
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	sms_link_if.host link,
	input wire sms_pkg::sms_mode_type mode_sel,
	input wire logic strap_en,
	input wire logic restart,
	input wire logic [sms_pkg::DATA_W-1:0] xfer_data,
	input wire logic xfer_last,
	input wire logic xfer_valid,
	output logic xfer_ready,
	output logic [sms_pkg::DATA_W-1:0] rx_data,
	output logic rx_valid,
	output logic busy
);
	import sms_pkg::*;
	typedef enum logic [2:0] {H_RESET, H_IDLE, H_SETUP, H_FIRST, H_SECOND, H_GAP, H_END}
		sms_hstate_type;
	sms_hstate_type st_q, st_d;
	logic [15:0] tick_q, tick_d;
	logic [DATA_W-1:0] tx_q, tx_d, rx_q, rx_d, rxo_q, rxo_d;
	logic [$clog2(DATA_W)-1:0] bit_q, bit_d;
	sms_mode_type mode_q, mode_d;
	logic sclk_q, sclk_d, cs_q, cs_d, rstp_q, rstp_d, last_q, last_d, rxv_q, rxv_d;
	logic miso_meta_q, miso_q, tick, take;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			miso_meta_q <= 1'b0;
			miso_q <= 1'b0;
		end else begin
			miso_meta_q <= link.slave_serial_output;
			miso_q <= miso_meta_q;
		end
	end
	assign tick = tick_q == 16'(HALF_CYC - 1);
	assign take = (st_q == H_IDLE || st_q == H_GAP) && xfer_valid;
	always_comb begin
		st_d = st_q;
		tick_d = tick ? '0 : tick_q + 1'b1;
		tx_d = tx_q;
		rx_d = rx_q;
		rxo_d = rxo_q;
		bit_d = bit_q;
		mode_d = mode_q;
		sclk_d = sclk_q;
		cs_d = cs_q;
		rstp_d = rstp_q;
		last_d = last_q;
		rxv_d = 1'b0;
		unique case (st_q)
			H_RESET: begin
				rstp_d = 1'b0;
				cs_d = 1'b1;
				mode_d = strap_en ? mode_sel : MODE_RESET;
				sclk_d = mode_d[MODE_POL];
				tick_d = tick_q + 1'b1;
				if (tick_q == 16'(RST_CYC - 1)) begin
					rstp_d = 1'b1;
					st_d = H_IDLE;
				end
			end
			H_IDLE, H_GAP: begin
				tick_d = '0;
				if (take) begin
					tx_d = xfer_data;
					last_d = xfer_last;
					bit_d = '0;
					cs_d = 1'b0;
					st_d = H_SETUP;
				end
			end
			H_SETUP, H_FIRST: begin
				if (tick) begin
					sclk_d = ~mode_q[MODE_POL];
					if (!mode_q[MODE_PHA]) begin
						rx_d = {rx_q[DATA_W-2:0], miso_q};
					end else if (st_q == H_FIRST) begin
						tx_d = {tx_q[DATA_W-2:0], 1'b0};
					end
					st_d = H_SECOND;
				end
			end
			H_SECOND: begin
				if (tick) begin
					sclk_d = mode_q[MODE_POL];
					if (mode_q[MODE_PHA]) begin
						rx_d = {rx_q[DATA_W-2:0], miso_q};
					end else begin
						tx_d = {tx_q[DATA_W-2:0], 1'b0};
					end
					bit_d = bit_q + 1'b1;
					st_d = H_FIRST;
					if (bit_q == ($clog2(DATA_W))'(DATA_W-1)) begin
						rxo_d = rx_d;
						rxv_d = 1'b1;
						st_d = last_q ? H_END : H_GAP;
					end
				end
			end
			H_END: begin
				if (tick) begin
					cs_d = 1'b1;
					st_d = H_IDLE;
				end
			end
		endcase
		if (restart) begin
			// drop the pin on the restart edge so it stays low for the full hold count
			st_d = H_RESET;
			tick_d = '0;
			rstp_d = 1'b0;
			cs_d = 1'b1;
		end
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= H_RESET;
			tick_q <= '0;
			tx_q <= '0;
			rx_q <= '0;
			rxo_q <= '0;
			bit_q <= '0;
			mode_q <= MODE_RESET;
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
			rstp_q <= 1'b0;
			last_q <= 1'b0;
			rxv_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tick_q <= tick_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			rxo_q <= rxo_d;
			bit_q <= bit_d;
			mode_q <= mode_d;
			sclk_q <= sclk_d;
			cs_q <= cs_d;
			rstp_q <= rstp_d;
			last_q <= last_d;
			rxv_q <= rxv_d;
		end
	end
	assign xfer_ready = take;
	assign rx_data = rxo_q;
	assign rx_valid = rxv_q;
	assign busy = st_q != H_IDLE;
	assign link.sclk = sclk_q;
	assign link.slave_select_low = cs_q;
	assign link.mosi = tx_q[DATA_W-1];
	assign link.active_low_reset_pin = rstp_q;
	// straps driven only when asked; otherwise the pull-downs decide
	assign link.clock_polarity_select_o = mode_q[MODE_POL];
	assign link.clock_polarity_select_oe = strap_en;
	assign link.clock_phase_select_o = mode_q[MODE_PHA];
	assign link.clock_phase_select_oe = strap_en;
endmodule // sms_host
`default_nettype wire

// ---- bench/sms_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module sms_asserts (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic slave_select_low,
	input wire logic active_low_reset_pin,
	input wire logic clock_polarity_select,
	input wire logic clock_phase_select,
	input wire logic slave_serial_output_o,
	input wire logic slave_serial_output_oe
);
	import sms_pkg::*;
	logic sclk_q, pin_q, launch;
	sms_mode_type mode_q, mode_d;
	logic [3:0] age_q, age_d, fr_q, fr_d;
	always_comb begin
		mode_d = mode_q;
		if (active_low_reset_pin && !pin_q)
			mode_d = {clock_polarity_select, clock_phase_select};
		// launch edge is the rise when polarity and phase differ
		launch = (mode_q[MODE_POL] ^ mode_q[MODE_PHA]) ? (sclk && !sclk_q) : (!sclk && sclk_q);
		age_d = launch ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
		fr_d = (!slave_serial_output_oe || slave_select_low) ? 4'h0 : fr_q + {3'h0, fr_q != 4'hf};
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sclk_q <= 1'b0;
			pin_q <= 1'b0;
			mode_q <= MODE_RESET;
			age_q <= 4'h0;
			fr_q <= 4'h0;
		end else begin
			sclk_q <= sclk;
			pin_q <= active_low_reset_pin;
			mode_q <= mode_d;
			age_q <= age_d;
			fr_q <= fr_d;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence s_move(sms_mode_type m);
		fr_q > 4'h4 && mode_q == m && $changed(slave_serial_output_o);
	endsequence
	sequence s_idle(logic p);
		active_low_reset_pin && $past(active_low_reset_pin, 2) && slave_select_low
			&& $past(slave_select_low) && mode_q[MODE_POL] == p;
	endsequence
	property p_launch(sms_mode_type m);
		s_move(m) |-> age_q inside {[4'h1:4'h4]};
	endproperty
	AST_MODE0_LAUNCH: assert property (p_launch(2'h0))
		else $error("mode 0 output moved away from falling edge");
	AST_MODE1_LAUNCH: assert property (p_launch(2'h1))
		else $error("mode 1 output moved away from rising edge");
	AST_MODE2_LAUNCH: assert property (p_launch(2'h2))
		else $error("mode 2 output moved away from rising edge");
	AST_MODE3_LAUNCH: assert property (p_launch(2'h3))
		else $error("mode 3 output moved away from falling edge");
	AST_IDLE_LOW: assert property (s_idle(1'b0) |-> !sclk)
		else $error("serial clock not idle low");
	AST_IDLE_HIGH: assert property (s_idle(1'b1) |-> sclk)
		else $error("serial clock not idle high");
	AST_RELEASE: assert property (slave_select_low [*7] |-> !slave_serial_output_oe)
		else $error("output still driven while deselected");
	AST_DRIVE: assert property ((!slave_select_low && active_low_reset_pin) [*7]
		|-> slave_serial_output_oe)
		else $error("output not driven in frame");
endmodule // sms_asserts
`default_nettype wire

// ---- bench/spi_slave_mode_select_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module spi_slave_mode_select_tb;
	import sms_pkg::*;
	localparam int LIMIT = 20000;
	logic ref_clk = 1'b0;
	logic reset_n, strap_en, restart, xfer_last, xfer_valid, xfer_ready, h_rx_valid, busy;
	logic d_rx_valid, rx_ready, rx_space, tx_valid, tx_ready, frame_active;
	logic [DATA_W-1:0] xfer_data, h_rx_data, d_rx_data, tx_data, pat;
	sms_mode_type mode_sel, spi_mode;
	int dtx_i, fails, cmp_count, cycles;
	sms_link_if link_if ();
	sms_host #(.HALF_CYC(6), .RST_CYC(4)) u_sms_host (.ref_clk(ref_clk), .reset_n(reset_n),
		.link(link_if), .mode_sel(mode_sel), .strap_en(strap_en), .restart(restart),
		.xfer_data(xfer_data), .xfer_last(xfer_last), .xfer_valid(xfer_valid),
		.xfer_ready(xfer_ready), .rx_data(h_rx_data), .rx_valid(h_rx_valid), .busy(busy));
	sms_device #(.DEPTH(FIFO_DEPTH)) u_sms_device (.ref_clk(ref_clk), .reset_n(reset_n),
		.link(link_if), .rx_data(d_rx_data), .rx_valid(d_rx_valid), .rx_ready(rx_ready),
		.rx_space(rx_space), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.spi_mode(spi_mode), .frame_active(frame_active));
	sms_asserts u_sms_asserts (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(link_if.sclk),
		.slave_select_low(link_if.slave_select_low),
		.active_low_reset_pin(link_if.active_low_reset_pin),
		.clock_polarity_select(link_if.clock_polarity_select),
		.clock_phase_select(link_if.clock_phase_select),
		.slave_serial_output_o(link_if.slave_serial_output_o),
		.slave_serial_output_oe(link_if.slave_serial_output_oe));
	always #(CLK_PERIOD_NS / 2.0) ref_clk = ~ref_clk;
	// device transmit stream follows a pattern indexed by bytes taken
	always @(posedge ref_clk) begin
		if (tx_ready && tx_valid)
			dtx_i = dtx_i + 1;
		tx_valid <= 1'b1;
		tx_data <= pat + DATA_W'(dtx_i) * 8'h25;
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			$display("unexpected timeout at %0t: got %h expected %h", $time, cycles, LIMIT);
			test_done();
		end
	end
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (busy !== 1'b0 && n < 1000);
		chk({7'h0, busy}, 8'h00);
	endtask
	task automatic xfer(input logic [DATA_W-1:0] d, input logic last, input logic [DATA_W-1:0] e);
		int n;
		xfer_data <= d;
		xfer_last <= last;
		xfer_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (xfer_ready !== 1'b1 && n < 400);
		chk({7'h0, xfer_ready}, 8'h01);
		xfer_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (h_rx_valid !== 1'b1 && n < 400);
		chk({7'h0, h_rx_valid}, 8'h01);
		chk(h_rx_data, e);
	endtask
	task automatic frame(input int n, input logic [DATA_W-1:0] hb);
		dtx_i = 0;
		for (int k = 0; k < n; k++) begin
			xfer(hb + DATA_W'(k), k == n - 1, pat + DATA_W'(k) * 8'h25);
		end
		repeat (30) @(posedge ref_clk);
	endtask
	task automatic drain(input int n, input logic [DATA_W-1:0] hb);
		int k;
		k = 0;
		rx_ready <= 1'b1;
		repeat (n + 4) begin
			@(posedge ref_clk);
			if (d_rx_valid === 1'b1) begin
				chk(d_rx_data, hb + DATA_W'(k));
				k++;
			end
		end
		rx_ready <= 1'b0;
		chk(DATA_W'(k), DATA_W'(n));
	endtask
	task automatic restart_to(input sms_mode_type m, input logic en);
		mode_sel <= m;
		strap_en <= en;
		restart <= 1'b1;
		@(posedge ref_clk);
		restart <= 1'b0;
		repeat (3) @(posedge ref_clk);
		wait_idle();
		repeat (8) @(posedge ref_clk);
		chk(DATA_W'(spi_mode), en ? DATA_W'(m) : 8'h00);
	endtask
	initial begin
		{reset_n, strap_en, restart, xfer_last, xfer_valid, rx_ready, tx_valid} = '0;
		{mode_sel, xfer_data, tx_data, pat} = '0;
		{dtx_i, fails, cmp_count, cycles} = '0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		wait_idle();
		repeat (8) @(posedge ref_clk);
		chk(DATA_W'(spi_mode), 8'h00);
		for (int m = 0; m < 4; m++) begin
			pat <= 8'h3c + DATA_W'(m) * 8'h51;
			restart_to(sms_mode_type'(m), 1'b1);
			frame(3, 8'h10 + DATA_W'(m) * 8'h10);
			chk({7'h0, link_if.slave_serial_output_oe}, 8'h00);
			chk({7'h0, frame_active}, 8'h00);
			chk({7'h0, link_if.sclk}, DATA_W'(m / 2));
			drain(3, 8'h10 + DATA_W'(m) * 8'h10);
			$display("test mode %0d done", m);
		end
		// straps fall back to the pull-down level after the latch
		strap_en <= 1'b0;
		frame(2, 8'h70);
		chk(DATA_W'(spi_mode), 8'h03);
		drain(2, 8'h70);
		$display("test mode hold done");
		frame(17, 8'h80);
		chk({7'h0, rx_space}, 8'h00);
		drain(16, 8'h80);
		chk({7'h0, rx_space}, 8'h01);
		$display("test buffer done");
		restart_to(2'h3, 1'b0);
		frame(1, 8'hc0);
		drain(1, 8'hc0);
		$display("test default mode done");
		test_done();
	end
endmodule // spi_slave_mode_select_tb
`default_nettype wire
